// ---- src/prefetch_ctrl_pkg.sv ----
package prefetch_ctrl_pkg;

    // Register indices; byte address is four times the index
    localparam logic [7:0]  IDX_RESERVED_BYTE  = 8'h5f;
    localparam logic [7:0]  IDX_READ_PREFETCH  = 8'h60;
    localparam logic [7:0]  IDX_PCI_BUS_CTRL   = 8'h63;
    localparam int          ADDR_IDX_LSB       = 2;
    localparam int          ADDR_IDX_MSB       = 9;

    // Read prefetch control fields
    localparam int LINE_INIT_LSB  = 19;
    localparam int MULT_INIT_LSB  = 16;
    localparam int LINE_CONT_BIT  = 11;
    localparam int MULT_CONT_BIT  = 10;
    localparam int DELAYED_LSB    = 8;
    localparam int LINE_CNT_LSB   = 5;
    localparam int MULT_CNT_LSB   = 2;
    localparam int RD_PF_BIT      = 1;
    localparam int PF_EN_BIT      = 0;
    localparam logic [23:0] READ_PF_WMASK = 24'h3f0fff;

    // Bus control fields
    localparam int TRQ_BIT        = 5;
    localparam int PARK_BIT       = 4;
    localparam int CHARGE_LSB     = 0;
    localparam logic [7:0]  BUS_CTRL_WMASK = 8'h3f;
    localparam logic [3:0]  CHARGE_RESET   = 4'hf;

    // Reset values
    localparam logic [23:0] READ_PF_RESET_BRIDGE  = 24'h000000;
    localparam logic [23:0] READ_PF_RESET_GENERIC = 24'h000001;
    localparam logic [7:0]  BUS_CTRL_RESET        = 8'h0f;

    localparam int NUM_MASTERS = 4;
    localparam int WORD_W      = 32;
    localparam int FIFO_DEPTH  = 8;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD    = 3'h2;

    typedef enum logic [1:0] {
        CMD_MEM_READ  = 2'b00,
        CMD_READ_LINE = 2'b01,
        CMD_READ_MULT = 2'b10
    } read_cmd_t;

    typedef struct packed {
        read_cmd_t  cmd;
        logic [31:0] addr;
    } read_req_t;

    typedef struct packed {
        logic        line_end;
        logic [31:0] data;
    } line_word_t;

    localparam int LINE_WORD_W = WORD_W + 1;

endpackage

// ---- src/pci_read_prefetch_and_bus_control.sv ----
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none

module line_fifo
    import prefetch_ctrl_pkg::*;
#(
    parameter int WIDTH = 33,
    parameter int DEPTH = 8
) (
    input  wire logic             hclk,
    input  wire logic             hresetn,
    input  wire logic             flush,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg, wr_next, rd_reg, rd_next;
    logic [AW:0]      cnt_reg, cnt_next;
    logic             push, pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wr_next  = flush ? '0 : (push ? wr_reg + 1'b1 : wr_reg);
        rd_next  = flush ? '0 : (pop ? rd_reg + 1'b1 : rd_reg);
        cnt_next = flush ? '0 : cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end

    always_ff @(posedge hclk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
endmodule

module pci_read_prefetch_and_bus_control
    import prefetch_ctrl_pkg::*;
#(
    parameter bit GENERIC_PORT_VARIANT = 1'b0
) (
    input  wire logic                   hclk,
    input  wire logic                   hresetn,
    input  wire logic                   warm_reset,
    input  wire logic                   hsel,
    input  wire logic [31:0]            haddr,
    input  wire logic [1:0]             htrans,
    input  wire logic                   hwrite,
    input  wire logic [2:0]             hsize,
    input  wire logic [31:0]            hwdata,
    input  wire logic                   hready,
    output logic                        hreadyout,
    output logic                        hresp,
    output logic      [31:0]            hrdata,
    input  wire logic                   req_valid,
    output logic                        req_ready,
    input  wire read_req_t              req,
    input  wire logic                   req_retire,
    output logic                        reconnect_ok,
    output logic                        fetch_valid,
    input  wire logic                   fetch_ready,
    output logic                        fetch_single,
    output logic      [31:0]            fetch_addr,
    input  wire logic                   up_valid,
    output logic                        up_ready,
    input  wire line_word_t             up_word,
    output logic                        pci_valid,
    input  wire logic                   pci_ready,
    output line_word_t                  pci_word,
    input  wire logic [NUM_MASTERS-1:0] pci_req_n,
    output logic      [NUM_MASTERS-1:0] pci_gnt_n,
    input  wire logic                   cfg_type0_start,
    output logic                        ad_drive,
    output logic                        frame_start
);
    localparam logic [23:0] READ_PF_RESET =
        GENERIC_PORT_VARIANT ? READ_PF_RESET_GENERIC : READ_PF_RESET_BRIDGE;

    // Register bus
    logic [23:0] read_pf_reg, read_pf_next;
    logic [7:0]  bus_ctrl_reg, bus_ctrl_next;
    logic [31:0] hrdata_reg, hrdata_next;
    logic        wr_pend_reg, wr_pend_next;
    logic [7:0]  wr_idx_reg, wr_idx_next;
    logic        addr_ok;
    logic [7:0]  idx;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;
    assign idx       = haddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
    assign addr_ok   = hsel && hready && (htrans == HTRANS_NONSEQ)
                       && (haddr[31:ADDR_IDX_MSB+1] == '0);

    always_comb begin
        read_pf_next  = read_pf_reg;
        bus_ctrl_next = bus_ctrl_reg;
        wr_pend_next  = addr_ok && hwrite && (hsize == HSIZE_WORD);
        wr_idx_next   = idx;
        hrdata_next   = '0;
        if (addr_ok && !hwrite) begin
            case (idx)
                IDX_READ_PREFETCH: hrdata_next = {8'h00, read_pf_reg};
                IDX_PCI_BUS_CTRL:  hrdata_next = {24'h000000, bus_ctrl_reg};
                default:           hrdata_next = '0;
            endcase
        end
        if (wr_pend_reg) begin
            case (wr_idx_reg)
                IDX_READ_PREFETCH:
                    read_pf_next = hwdata[23:0] & READ_PF_WMASK;
                IDX_PCI_BUS_CTRL:
                    bus_ctrl_next = hwdata[7:0] & BUS_CTRL_WMASK;
                default: ;
            endcase
        end
        if (warm_reset) begin
            read_pf_next  = READ_PF_RESET;
            bus_ctrl_next = BUS_CTRL_RESET;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            read_pf_reg  <= READ_PF_RESET;
            bus_ctrl_reg <= BUS_CTRL_RESET;
            hrdata_reg   <= '0;
            wr_pend_reg  <= 1'b0;
            wr_idx_reg   <= '0;
        end else begin
            read_pf_reg  <= read_pf_next;
            bus_ctrl_reg <= bus_ctrl_next;
            hrdata_reg   <= hrdata_next;
            wr_pend_reg  <= wr_pend_next;
            wr_idx_reg   <= wr_idx_next;
        end
    end

    // Field views
    logic [2:0] line_init, mult_init, line_cnt, mult_cnt;
    logic [1:0] delayed_max;
    logic       line_cont, mult_cont, rd_pf_en, pf_en, park_zero;
    logic [3:0] charge;
    assign line_init   = read_pf_reg[LINE_INIT_LSB +: 3];
    assign mult_init   = read_pf_reg[MULT_INIT_LSB +: 3];
    assign line_cont   = read_pf_reg[LINE_CONT_BIT];
    assign mult_cont   = read_pf_reg[MULT_CONT_BIT];
    assign delayed_max = read_pf_reg[DELAYED_LSB +: 2];
    assign line_cnt    = read_pf_reg[LINE_CNT_LSB +: 3];
    assign mult_cnt    = read_pf_reg[MULT_CNT_LSB +: 3];
    assign rd_pf_en    = read_pf_reg[RD_PF_BIT];
    assign pf_en       = read_pf_reg[PF_EN_BIT];
    assign park_zero   = bus_ctrl_reg[PARK_BIT];
    assign charge      = bus_ctrl_reg[CHARGE_LSB +: 4];

    // Prefetch engine
    typedef enum logic [1:0] {
        ENG_IDLE  = 2'b00,
        ENG_FETCH = 2'b01
    } eng_state_t;

    eng_state_t  eng_reg, eng_next;
    logic [2:0]  outst_reg, outst_next;
    logic [7:0]  pend_reg, pend_next;
    logic [3:0]  fetched_reg, fetched_next;
    logic [3:0]  need_reg, need_next;
    logic        cont_reg, cont_next, single_reg, single_next;
    logic        mult_reg, mult_next;
    logic [31:0] addr_reg, addr_next;
    logic        accept, issue, up_take, line_back, use_line, prefetch;
    logic        fifo_in_valid;
    logic [LINE_WORD_W-1:0] fifo_out;

    assign use_line  = (req.cmd == CMD_READ_LINE)
                       || (req.cmd == CMD_MEM_READ && rd_pf_en);
    assign prefetch  = pf_en && (use_line || req.cmd == CMD_READ_MULT);
    assign req_ready = (eng_reg == ENG_IDLE)
                       && (outst_reg <= {1'b0, delayed_max});
    assign accept    = req_valid && req_ready;
    assign fetch_valid  = (eng_reg == ENG_FETCH) && (pend_reg != '0);
    assign fetch_single = single_reg;
    assign fetch_addr   = addr_reg;
    assign issue     = fetch_valid && fetch_ready;
    assign fifo_in_valid = up_valid && (eng_reg == ENG_FETCH);
    assign up_take   = fifo_in_valid && up_ready && up_word.line_end;
    assign line_back = pci_valid && pci_ready && pci_word.line_end;
    assign pci_word  = line_word_t'(fifo_out);
    assign reconnect_ok = (eng_reg == ENG_FETCH)
                          && (fetched_reg >= need_reg);

    always_comb begin
        eng_next     = eng_reg;
        outst_next   = outst_reg + 3'(accept)
                       - 3'(req_retire && outst_reg != '0);
        pend_next    = pend_reg;
        fetched_next = fetched_reg;
        need_next    = need_reg;
        cont_next    = cont_reg;
        single_next  = single_reg;
        mult_next    = mult_reg;
        addr_next    = addr_reg;
        case (eng_reg)
            ENG_IDLE: begin
                if (accept) begin
                    eng_next     = ENG_FETCH;
                    fetched_next = '0;
                    addr_next    = req.addr;
                    mult_next    = (req.cmd == CMD_READ_MULT);
                    single_next  = !prefetch;
                    if (!prefetch) begin
                        pend_next = 8'h01;
                        need_next = 4'h1;
                        cont_next = 1'b0;
                    end else if (req.cmd == CMD_READ_MULT) begin
                        pend_next = 8'h01 + 8'(mult_cnt);
                        need_next = 4'(mult_init);
                        cont_next = mult_cont;
                    end else begin
                        pend_next = 8'h01 + 8'(line_cnt);
                        need_next = 4'(line_init);
                        cont_next = line_cont;
                    end
                end
            end
            ENG_FETCH: begin
                pend_next = pend_reg - 8'(issue)
                            + 8'(line_back && cont_reg);
                if (up_take && fetched_reg != 4'hf) begin
                    fetched_next = fetched_reg + 4'h1;
                end
                if (req_retire) begin
                    eng_next = ENG_IDLE;
                end
            end
            default: eng_next = ENG_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            eng_reg     <= ENG_IDLE;
            outst_reg   <= '0;
            pend_reg    <= '0;
            fetched_reg <= '0;
            need_reg    <= '0;
            cont_reg    <= 1'b0;
            single_reg  <= 1'b0;
            mult_reg    <= 1'b0;
            addr_reg    <= '0;
        end else begin
            eng_reg     <= eng_next;
            outst_reg   <= outst_next;
            pend_reg    <= pend_next;
            fetched_reg <= fetched_next;
            need_reg    <= need_next;
            cont_reg    <= cont_next;
            single_reg  <= single_next;
            mult_reg    <= mult_next;
            addr_reg    <= addr_next;
        end
    end

    line_fifo #(.WIDTH(LINE_WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .flush     (req_retire || warm_reset),
        .in_valid  (fifo_in_valid),
        .in_ready  (up_ready),
        .in_data   (up_word),
        .out_valid (pci_valid),
        .out_ready (pci_ready),
        .out_data  (fifo_out)
    );

    // Arbiter with parking
    logic [NUM_MASTERS-1:0] req_s1_reg, req_s2_reg, gnt_reg, gnt_next;
    logic [NUM_MASTERS-1:0] req_act;
    assign req_act   = ~req_s2_reg;
    assign pci_gnt_n = ~gnt_reg;

    always_comb begin
        gnt_next = gnt_reg;
        if (req_act == '0) begin
            if (park_zero) begin
                gnt_next = NUM_MASTERS'(1);
            end
        end else begin
            gnt_next = req_act & (~req_act + NUM_MASTERS'(1));
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_s1_reg <= '1;
            req_s2_reg <= '1;
            gnt_reg    <= NUM_MASTERS'(1);
        end else begin
            req_s1_reg <= pci_req_n;
            req_s2_reg <= req_s1_reg;
            gnt_reg    <= warm_reset ? NUM_MASTERS'(1) : gnt_next;
        end
    end

    // Type 0 configuration address charge
    typedef enum logic [1:0] {
        CFG_IDLE   = 2'b00,
        CFG_CHARGE = 2'b01
    } cfg_state_t;

    cfg_state_t cfg_reg, cfg_next;
    logic [3:0] chg_reg, chg_next;
    logic       frame_reg, frame_next;
    assign ad_drive    = (cfg_reg == CFG_CHARGE);
    assign frame_start = frame_reg;

    always_comb begin
        cfg_next   = cfg_reg;
        chg_next   = chg_reg;
        frame_next = 1'b0;
        case (cfg_reg)
            CFG_IDLE: begin
                if (cfg_type0_start) begin
                    if (charge == '0) begin
                        frame_next = 1'b1;
                    end else begin
                        cfg_next = CFG_CHARGE;
                        chg_next = charge;
                    end
                end
            end
            CFG_CHARGE: begin
                chg_next = chg_reg - 4'h1;
                if (chg_reg == 4'h1) begin
                    cfg_next   = CFG_IDLE;
                    frame_next = 1'b1;
                end
            end
            default: cfg_next = CFG_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_reg   <= CFG_IDLE;
            chg_reg   <= '0;
            frame_reg <= 1'b0;
        end else begin
            cfg_reg   <= cfg_next;
            chg_reg   <= chg_next;
            frame_reg <= frame_next;
        end
    end

    // Checks
    logic [3:0] drive_cnt_reg;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_cnt_reg <= '0;
        end else begin
            drive_cnt_reg <= ad_drive ? drive_cnt_reg + 4'h1 : '0;
        end
    end

    sequence cfg_begin_s;
        cfg_type0_start && cfg_reg == CFG_IDLE && charge == 4'h3;
    endsequence
    sequence charge_three_s;
        ad_drive [*3] ##1 frame_start;
    endsequence

    chk_reconnect_line: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && prefetch && req.cmd != CMD_READ_MULT
        |=> need_reg == 4'($past(line_init))
            && reconnect_ok == ($past(line_init) == 3'h0))
        else $error("line reconnect count not loaded");
    chk_reconnect_mult: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && prefetch && req.cmd == CMD_READ_MULT
        |=> need_reg == 4'(mult_init))
        else $error("multiple initial count not loaded");
    chk_window_grow: assert property (@(posedge hclk) disable iff (!hresetn)
        eng_reg == ENG_FETCH && cont_reg && line_back && !issue && !req_retire
        |=> pend_reg == $past(pend_reg) + 8'h01)
        else $error("window did not grow on returned line");
    chk_delayed_limit: assert property (@(posedge hclk) disable iff (!hresetn)
        outst_reg > {1'b0, delayed_max} |-> !req_ready)
        else $error("too many delayed requests accepted");
    chk_line_depth: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && prefetch && req.cmd == CMD_READ_LINE
        |=> pend_reg == 8'h01 + 8'($past(line_cnt)))
        else $error("line prefetch depth wrong");
    chk_global_gate: assert property (@(posedge hclk) disable iff (!hresetn)
        accept && !pf_en |=> single_reg && pend_reg == 8'h01)
        else $error("prefetch while disabled");
    chk_warm_fields: assert property (@(posedge hclk) disable iff (!hresetn)
        warm_reset |=> read_pf_reg == READ_PF_RESET
                       && bus_ctrl_reg == BUS_CTRL_RESET)
        else $error("warm reset did not restore fields");
    chk_park_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        req_act == '0 && park_zero && !warm_reset |=> gnt_reg == NUM_MASTERS'(1))
        else $error("grant not parked on line zero");
    chk_charge_seq: assert property (@(posedge hclk) disable iff (!hresetn)
        cfg_begin_s |=> charge_three_s)
        else $error("charge time not honoured");
    chk_charge_count: assert property (@(posedge hclk) disable iff (!hresetn)
        frame_start && $past(ad_drive) |-> $past(drive_cnt_reg) + 4'h1
                                           == $past(charge))
        else $error("frame after wrong charge count");
    chk_rsvd_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        (read_pf_reg & ~READ_PF_WMASK) == '0 && bus_ctrl_reg[7:6] == '0)
        else $error("reserved bits not zero");
endmodule

`default_nettype wire

// ---- tb/upstream_model.sv ----
`timescale 1ns/1ps
`default_nettype none

module upstream_model
    import prefetch_ctrl_pkg::*;
(
    input  wire logic  hclk,
    input  wire logic  hresetn,
    input  wire logic  stall,
    input  wire logic  flush,
    input  wire logic  fetch_valid,
    output logic       fetch_ready,
    output logic       up_valid,
    input  wire logic  up_ready,
    output line_word_t up_word
);
    int          lines;
    logic [1:0]  beat;
    logic [31:0] data;

    // Slow mode refuses new fetches only
    assign fetch_ready = !stall;
    assign up_valid    = lines > 0;
    // Idle bus shows the inverted next word
    assign up_word = up_valid ? {beat == 2'h3, data} : {1'b0, ~data};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn || flush) begin
            lines <= 0;
            beat  <= 2'h0;
            data  <= 32'h0;
        end else begin
            lines <= lines + int'(fetch_valid && fetch_ready)
                     - int'(up_valid && up_ready && beat == 2'h3);
            if (up_valid && up_ready) begin
                beat <= beat + 2'h1;
                data <= data + 32'h1;
            end
        end
    end
endmodule

`default_nettype wire

// ---- tb/tb_pci_read_prefetch_and_bus_control.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_pci_read_prefetch_and_bus_control
    import prefetch_ctrl_pkg::*;
;
    logic        hclk = 0, hresetn = 0, warm_reset = 0, hsel = 0;
    logic        hwrite = 0, req_valid = 0, req_retire = 0;
    logic        pci_ready = 0, cfg_type0_start = 0, stall = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, fetch_addr, rbits;
    logic [1:0]  htrans = 0;
    logic [2:0]  hsize = 0;
    logic [3:0]  pci_req_n = 4'hf, pci_gnt_n;
    read_req_t   req = '0;
    line_word_t  up_word, pci_word;
    logic        hreadyout, hresp, req_ready, reconnect_ok, fetch_valid;
    logic        fetch_ready, fetch_single, up_valid, up_ready, pci_valid;
    logic        ad_drive, frame_start, rd_phase = 0, cnt_clr = 0, rc_seen;
    logic [31:0] seed = 32'd8765;
    logic [31:0] exp_q[$], word_q[$], rval;
    int          fail_count = 0, checked = 0, fcount, lcount, rc_lines, n;
    int          dcount;

    always #12.5 hclk = ~hclk;

    pci_read_prefetch_and_bus_control pci_read_prefetch_and_bus_control_i (
        .hclk(hclk), .hresetn(hresetn), .warm_reset(warm_reset),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .req_retire(req_retire), .reconnect_ok(reconnect_ok),
        .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
        .fetch_single(fetch_single), .fetch_addr(fetch_addr),
        .up_valid(up_valid), .up_ready(up_ready), .up_word(up_word),
        .pci_valid(pci_valid), .pci_ready(pci_ready), .pci_word(pci_word),
        .pci_req_n(pci_req_n), .pci_gnt_n(pci_gnt_n),
        .cfg_type0_start(cfg_type0_start), .ad_drive(ad_drive),
        .frame_start(frame_start));

    upstream_model upstream_model_i (
        .hclk(hclk), .hresetn(hresetn), .stall(stall), .flush(req_retire),
        .fetch_valid(fetch_valid), .fetch_ready(fetch_ready),
        .up_valid(up_valid), .up_ready(up_ready), .up_word(up_word));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wait_hready();
        int k;
        k = 0;
        do begin
            @(posedge hclk);
            k++;
        end while (hreadyout !== 1'b1 && k < 50);
        if (k >= 50) begin
            check("hready timeout", 0, 1);
            stop_test();
        end
    endtask

    // One single-word transfer; reads note their expected data
    task automatic bus(logic wr, logic [31:0] a, d, e);
        @(posedge hclk);
        hsel <= 1;
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        haddr <= a;
        hsize <= HSIZE_WORD;
        wait_hready();
        htrans <= 2'h0;
        hwdata <= d;
        rd_phase <= !wr;
        if (!wr) exp_q.push_back(e);
        wait_hready();
        rd_phase <= 0;
        hsel <= 0;
    endtask

    // Read data monitor
    always @(posedge hclk) begin
        if (rd_phase && hreadyout === 1'b1)
            check("hrdata", hrdata, exp_q.pop_front());
    end

    // Fetch and line counters, far side stalls at random
    always @(posedge hclk) begin
        rbits = xs();
        pci_ready <= rbits[0] | rbits[1];
        stall <= rbits[2] & rbits[3];
        if (cnt_clr) begin
            fcount <= 0;
            lcount <= 0;
            rc_seen <= 0;
            rc_lines <= -1;
        end else begin
            if (fetch_valid && fetch_ready) fcount <= fcount + 1;
            if (up_valid && up_ready && up_word.line_end) lcount <= lcount + 1;
            if (reconnect_ok && !rc_seen) begin
                rc_seen <= 1;
                rc_lines <= lcount;
            end
        end
        // Words leave the FIFO in the order the far side sent them
        if (req_retire) begin
            word_q.delete();
        end else begin
            if (pci_valid && pci_ready)
                check("pci_word", pci_word.data, word_q.size() > 0 ?
                      word_q.pop_front() : ~pci_word.data);
            if (up_valid && up_ready) word_q.push_back(up_word.data);
        end
    end

    task automatic pf_run(read_cmd_t c, logic [31:0] cfg, int ef, es, erc,
                          logic cont);
        bus(1, 32'h180, cfg, 0);
        @(posedge hclk);
        cnt_clr <= 1;
        req <= '{c, xs()};
        req_valid <= 1;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (req_ready !== 1'b1 && n < 50);
        cnt_clr <= 0;
        req_valid <= 0;
        if (req_ready !== 1'b1) begin
            check("req timeout", 0, 1);
            stop_test();
        end
        for (n = 0; n < 2000 && fcount < ef; n++) @(posedge hclk);
        if (n >= 2000) begin
            check("fetch timeout", 0, 1);
            stop_test();
        end
        repeat (80) @(posedge hclk);
        check("fetches", cont ? ef + 1 : fcount,
              cont ? 32'(fcount > ef) * (ef + 1) : ef);
        check("single", fetch_single, es);
        check("fetch_addr", fetch_addr, req.addr);
        check("req_ready busy", req_ready, 0);
        check("reconnect lines", rc_lines, erc);
        @(posedge hclk);
        req_retire <= 1;
        @(posedge hclk);
        req_retire <= 0;
        $display("test prefetch cmd %0d done", c);
    endtask

    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1;
        bus(0, 32'h180, 0, READ_PF_RESET_BRIDGE);
        bus(0, 32'h18c, 0, 32'h0f);
        bus(0, 32'h17c, 0, 0);
        rval = xs();
        bus(1, 32'h180, rval, 0);
        bus(0, 32'h180, 0, rval & 32'h3f0fff);
        bus(1, 32'h18c, 32'hffffffff, 0);
        bus(0, 32'h18c, 0, 32'h3f);
        bus(1, 32'h184, 32'hffffffff, 0);
        bus(0, 32'h184, 0, 0);
        check("hresp", hresp, 0);
        @(posedge hclk);
        warm_reset <= 1;
        @(posedge hclk);
        warm_reset <= 0;
        bus(0, 32'h180, 0, 0);
        bus(0, 32'h18c, 0, 32'h0f);
        $display("test registers done");
        bus(1, 32'h18c, 32'h03, 0);
        pci_req_n <= 4'hb;
        repeat (6) @(posedge hclk);
        check("grant", pci_gnt_n, 4'hb);
        pci_req_n <= 4'hf;
        repeat (6) @(posedge hclk);
        check("park last", pci_gnt_n, 4'hb);
        bus(1, 32'h18c, 32'h13, 0);
        repeat (6) @(posedge hclk);
        check("park zero", pci_gnt_n, 4'he);
        cfg_type0_start <= 1;
        @(posedge hclk);
        cfg_type0_start <= 0;
        dcount = 0;
        for (n = 0; n < 40 && frame_start !== 1'b1; n++) begin
            @(posedge hclk);
            if (ad_drive === 1'b1) dcount++;
        end
        check("charge clocks", dcount, 3);
        $display("test arbiter and config done");
        bus(1, 32'h18c, 32'h20, 0);
        pf_run(CMD_READ_LINE, 32'h10004d, 3, 0, 2, 0);
        pf_run(CMD_READ_MULT, 32'h01004d, 4, 0, 1, 0);
        pf_run(CMD_MEM_READ, 32'h10004f, 3, 0, 2, 0);
        pf_run(CMD_MEM_READ, 32'h10004d, 1, 1, 1, 0);
        pf_run(CMD_READ_MULT, 32'h01004c, 1, 1, 1, 0);
        pf_run(CMD_READ_LINE, 32'h10084d, 3, 0, 2, 1);
        pf_run(CMD_READ_MULT, 32'h01044d, 4, 0, 1, 1);
        stop_test();
    end
endmodule

`default_nettype wire
